// [core/mcs_sequencer.sv]
`include "mcs_map.svh"

// Notes on behaviour
// [RULE1] input clock divided by four into four one-hot phases per cycle
// [RULE2] counter advances in phase one; fetched word captured in phase four
// [RULE3] fetch overlaps execution of the previous word, one per cycle
// [RULE4] counter-altering instructions take two cycles; fetched word flushed
// [RULE5] operand read in phase two, destination written in phase four
// [RULE6] in resistor-capacitor mode output a clock at quarter input rate
// [RULE7] master reset is active low and holds the device while low
// [RULE8] counter is 9 bits on smallest variant, 11 bits on larger ones
// [RULE9] addresses beyond implemented program memory wrap around
// [RULE10] reset vector is the last program word
// [RULE11] non-branching word at reset vector falls through to address zero
// [RULE12] larger variants choose program page from two status bits
// [RULE13] larger variants choose data bank from upper pointer bits
// [RULE14] smallest variant: 7 special, 25 general registers, no banks
// [RULE15] mid variant: 8 special, 8 plain, 64 banked general registers
// [RULE16] largest variant: 10 special, 6 plain, 128 banked general registers
// [RULE17] address zero has no storage; it reaches the pointed register
// [RULE18] smallest variant treats address 07h as a general register
// [RULE19] smaller variants treat 08h and 09h as general registers
// [RULE20] only low eight counter bits are visible as a register
// [RULE21] unimplemented port bits read as zero; unimplemented pointer bits read as one
// [RULE22] reset loads the counter with all ones
// [RULE23] reset clears the page select bits
// [RULE24] after reset start at phase one, fetch reset vector, execute nothing
// [RULE25] cycle after a taken branch changes no state besides fetching
module mcs_sequencer
    import mcs_pkg::*;
#(
    parameter int VARIANT = 2,
    parameter int PC_W = (VARIANT == 0) ? 9 : 11,
    parameter int PROG_WORDS = 1 << PC_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [PC_W-1:0] prog_addr,
    input wire logic [11:0] prog_data,
    output logic quarter_rate_clock_out,
    output logic [7:0] pin_direction_control,
    output logic [5:0] timer_prescale_config
);
    localparam logic [PC_W-1:0] PC_ONES = '1;
    localparam logic [PC_W-1:0] PC_MASK = PC_W'(PROG_WORDS - 1);
    localparam logic [4:0] SFR_COUNT = (VARIANT == 0) ? `MCS_SFR_V0 :
        (VARIANT == 1) ? `MCS_SFR_V1 : `MCS_SFR_V2;

    mcs_phase_t phase;
    logic first_cycle;
    logic [PC_W-1:0] pc;
    logic [11:0] fetch_word;
    logic [11:0] exec_word;
    logic exec_valid;
    logic branch;
    logic [PC_W-1:0] target;
    logic [PC_W-1:0] next_target;
    logic next_branch;
    logic [7:0] w_reg;
    logic [7:0] operand;
    logic [7:0] timer_count;
    logic [7:0] core_flags_and_page;
    logic [7:0] data_pointer;
    logic [7:0] port_one_pins;
    logic [7:0] port_two_pins;
    logic [7:0] port_three_pins;
    logic [7:0] port_four_pins;
    logic [7:0] port_five_pins;
    logic rc_mode;
    logic [7:0] general_purpose_register [0:255];
    mcs_op_t op;
    logic [7:0] core_a;
    logic [7:0] bus_idx;
    logic [7:0] bus_a;
    logic bus_file;
    logic bus_bad;
    logic bus_done;
    logic core_wr;
    logic wr_en;
    logic [7:0] wr_a;
    logic [7:0] wr_d;
    logic [31:0] bus_rdata;

    // map a 5-bit file address through the pointer into a storage address
    function automatic logic [7:0] resolve(input logic [4:0] f,
                                           input logic [7:0] ptr);
        logic [4:0] a;
        logic [2:0] bank;
        a = (f == `MCS_F_INDIRECT) ? ptr[4:0] : f; // RULE17
        bank = (VARIANT == 2) ? ptr[7:5] :
            (VARIANT == 1) ? {1'b0, ptr[6:5]} : 3'h0; // RULE13 RULE14
        resolve = (a < `MCS_F_BANKED) ? {3'h0, a} : {bank, a};
    endfunction : resolve

    // special registers sit below a variant-dependent limit, rest is storage
    function automatic logic is_sfr(input logic [7:0] a);
        is_sfr = (a[7:5] == 3'h0) && (a[4:0] < SFR_COUNT); // RULE18 RULE19
    endfunction : is_sfr

    // read one data file location as seen by core or bus
    function automatic logic [7:0] read_file(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (is_sfr(a)) begin
            case (a[4:0])
                `MCS_F_TIMER: v = timer_count;
                `MCS_F_PCL: v = pc[7:0]; // RULE20
                `MCS_F_STATUS: v = core_flags_and_page;
                `MCS_F_POINTER: v = data_pointer |
                    ((VARIANT == 0) ? `MCS_POINTER_OR_V0 :
                     (VARIANT == 1) ? `MCS_POINTER_OR_V1 : 8'h00);
                `MCS_F_PORT1: v = port_one_pins & `MCS_PORT1_MASK; // RULE21
                `MCS_F_PORT2: v = port_two_pins;
                `MCS_F_PORT3: v = port_three_pins;
                `MCS_F_PORT4: v = port_four_pins;
                `MCS_F_PORT5: v = port_five_pins & `MCS_PORT5_MASK; // RULE21
                default: v = 8'h00; // indirect through address zero
            endcase
        end else begin
            v = general_purpose_register[a];
        end
        read_file = v;
    endfunction : read_file

    // four-phase divider; starts at phase one out of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin // RULE7
            phase <= MCS_PH1; // RULE24
        end else begin
            case (phase) // RULE1
                MCS_PH1: phase <= MCS_PH2;
                MCS_PH2: phase <= MCS_PH3;
                MCS_PH3: phase <= MCS_PH4;
                MCS_PH4: phase <= MCS_PH1;
                default: phase <= MCS_PH1;
            endcase
        end
    end

    // quarter-rate clock is high in phases one and two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quarter_rate_clock_out <= 1'b0;
        end else begin
            quarter_rate_clock_out <= rc_mode &&
                (phase == MCS_PH4 || phase == MCS_PH1); // RULE6
        end
    end

    // program counter; first cycle holds the reset vector for the fetch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= PC_ONES; // RULE22 RULE10
            prog_addr <= PC_ONES & PC_MASK;
            first_cycle <= 1'b1;
        end else if (phase == MCS_PH1) begin // RULE2
            first_cycle <= 1'b0;
            if (first_cycle) begin
                pc <= pc; // RULE24
            end else if (branch) begin
                pc <= target; // RULE4
                prog_addr <= target & PC_MASK;
            end else begin
                pc <= pc + 1'b1; // RULE11 RULE8
                prog_addr <= (pc + 1'b1) & PC_MASK; // RULE9
            end
        end
    end

    // fetch latch and execute stage register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_word <= 12'h000;
            exec_word <= 12'h000;
            exec_valid <= 1'b0;
        end else begin
            if (phase == MCS_PH4) begin
                fetch_word <= prog_data; // RULE2
            end
            if (phase == MCS_PH1) begin
                exec_word <= fetch_word; // RULE3
                // a flushed word still moves but is marked dead
                exec_valid <= !first_cycle && !branch; // RULE4 RULE25
            end
        end
    end

    assign op = mcs_op_t'(exec_word[`MCS_OP_HI:`MCS_OP_LO]);
    assign core_a = resolve(exec_word[4:0], data_pointer);
    assign core_wr = (phase == MCS_PH4) && exec_valid && (op == MCS_STORE);

    // branch decision: a jump, or a store whose destination is the pcl
    always_comb begin
        next_branch = 1'b0;
        next_target = pc;
        if (exec_valid && op == MCS_JUMP) begin
            next_branch = 1'b1;
            next_target = PC_W'({core_flags_and_page[`MCS_PAGE_HI:
                `MCS_PAGE_LO], exec_word[8:0]}); // RULE12
        end else if (exec_valid && op == MCS_STORE && is_sfr(core_a) &&
                     core_a[4:0] == `MCS_F_PCL) begin
            next_branch = 1'b1;
            next_target = PC_W'({core_flags_and_page[`MCS_PAGE_HI:
                `MCS_PAGE_LO], 1'b0, w_reg});
        end
    end

    // branch flag is raised at end of execution, consumed at next phase one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            branch <= 1'b0;
            target <= PC_ONES;
        end else if (phase == MCS_PH4) begin
            branch <= next_branch; // RULE4
            target <= next_target;
        end else if (phase == MCS_PH1) begin
            branch <= 1'b0;
        end
    end

    // operand fetched in phase two, working register updated in phase four
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operand <= 8'h00;
            w_reg <= 8'h00;
        end else begin
            if (phase == MCS_PH2) begin
                operand <= read_file(core_a); // RULE5
            end
            if (phase == MCS_PH4 && exec_valid) begin
                if (op == MCS_LIT) begin
                    w_reg <= exec_word[7:0];
                end else if (op == MCS_LOAD) begin
                    w_reg <= operand; // RULE5
                end
            end
        end
    end

    // bus decode: the data file sits at indexes 00h-1fh, extras above
    assign bus_idx = paddr[9:2];
    assign bus_file = (bus_idx <= `MCS_IDX_FILE_TOP);
    assign bus_a = resolve(bus_idx[4:0], data_pointer);
    assign bus_bad = (paddr[31:10] != 22'h0) || (paddr[1:0] != 2'h0) ||
        (bus_idx > `MCS_IDX_STATE);
    assign bus_done = psel && penable && pready;

    // one write port; the bus never completes on a core write edge
    always_comb begin
        wr_en = core_wr;
        wr_a = core_a;
        wr_d = w_reg;
        if (bus_done && pwrite && !bus_bad && bus_file) begin
            wr_en = 1'b1;
            wr_a = bus_a;
            wr_d = pwdata[7:0];
        end
    end

    // general registers: plain storage, left uninitialised
    always_ff @(posedge pclk) begin
        if (wr_en && !is_sfr(wr_a)) begin
            general_purpose_register[wr_a] <= wr_d; // RULE5 RULE15 RULE16
        end
    end

    // core special registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_count <= 8'h00;
            core_flags_and_page <= `MCS_STATUS_RST; // RULE23
            data_pointer <= `MCS_POINTER_RST;
        end else if (wr_en && is_sfr(wr_a)) begin
            case (wr_a[4:0])
                `MCS_F_TIMER: timer_count <= wr_d;
                // flag bits 4:3 are read-only and keep their value
                `MCS_F_STATUS: core_flags_and_page <= (core_flags_and_page &
                    ~`MCS_STATUS_WMASK) | (wr_d & `MCS_STATUS_WMASK);
                `MCS_F_POINTER: data_pointer <= wr_d;
                default: timer_count <= timer_count;
            endcase
        end
    end

    // port latches; only present ports are decoded as special registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_one_pins <= 8'h00;
            port_two_pins <= 8'h00;
            port_three_pins <= 8'h00;
            port_four_pins <= 8'h00;
            port_five_pins <= 8'h00;
        end else if (wr_en && is_sfr(wr_a)) begin
            case (wr_a[4:0])
                `MCS_F_PORT1: port_one_pins <= wr_d & `MCS_PORT1_MASK;
                `MCS_F_PORT2: port_two_pins <= wr_d;
                `MCS_F_PORT3: port_three_pins <= wr_d;
                `MCS_F_PORT4: port_four_pins <= wr_d;
                `MCS_F_PORT5: port_five_pins <= wr_d & `MCS_PORT5_MASK;
                default: port_two_pins <= port_two_pins;
            endcase
        end
    end

    // configuration registers reached only from the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_mode <= 1'b0;
            pin_direction_control <= `MCS_PIN_DIRECTION_CONTROL_RST;
            timer_prescale_config <= `MCS_OPTION_RST;
        end else if (bus_done && pwrite && !bus_bad) begin
            case (bus_idx)
                `MCS_IDX_CTRL: rc_mode <= pwdata[`MCS_CTRL_RC_BIT];
                `MCS_IDX_PIN_DIRECTION_CONTROL: pin_direction_control <= pwdata[7:0];
                `MCS_IDX_OPTION: timer_prescale_config <= pwdata[5:0];
                default: rc_mode <= rc_mode;
            endcase
        end
    end

    // bus read value
    always_comb begin
        bus_rdata = 32'h0;
        if (bus_file) begin
            bus_rdata = {24'h0, read_file(bus_a)};
        end else begin
            case (bus_idx)
                `MCS_IDX_CTRL: bus_rdata = {31'h0, rc_mode};
                `MCS_IDX_PIN_DIRECTION_CONTROL: bus_rdata = {24'h0, pin_direction_control};
                `MCS_IDX_OPTION: bus_rdata = {26'h0, timer_prescale_config};
                `MCS_IDX_STATE: bus_rdata = {8'h0, w_reg, 5'h0,
                    11'(pc)};
                default: bus_rdata = 32'h0;
            endcase
        end
    end

    // ready is withheld so completion never lands on a phase four edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && !pready && phase != MCS_PH3) begin
            pready <= 1'b1;
            prdata <= (pwrite || bus_bad) ? 32'h0 : bus_rdata;
            pslverr <= bus_bad;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_phase_wrap: assert property (phase == MCS_PH4 |=> // RULE1
        phase == MCS_PH1 ##1 phase == MCS_PH2 ##1 phase == MCS_PH3)
        else $error("phase sequence broken");
    a_pc_hold: assert property (phase != MCS_PH1 |=> $stable(pc)) // RULE2
        else $error("counter moved outside phase one");
    a_fetch_latch: assert property (phase == MCS_PH4 |=> // RULE2
        fetch_word == $past(prog_data))
        else $error("fetch word not captured in phase four");
    a_stream_rate: assert property (phase == MCS_PH1 && !branch && // RULE3
        !first_cycle |=> exec_valid)
        else $error("straight-line word not executed");
    a_branch_flush: assert property ( // RULE4 RULE25
        phase == MCS_PH1 && branch |=> !exec_valid && pc == $past(target))
        else $error("branch did not flush or load target");
    a_store_write: assert property (core_wr && !is_sfr(core_a) |=> // RULE5
        general_purpose_register[$past(core_a)] == $past(w_reg))
        else $error("store not written in phase four");
    a_pc_increment: assert property (phase == MCS_PH1 && !branch && // RULE11
        !first_cycle |=> pc == PC_W'($past(pc) + 1'b1))
        else $error("counter did not advance by one");
    a_reset_fetch: assert property (first_cycle |-> // RULE10 RULE24
        pc == PC_ONES && !exec_valid)
        else $error("first fetch not from reset vector");
    a_quarter_clock: assert property (rc_mode && phase == MCS_PH4 // RULE6
        ##1 rc_mode |-> quarter_rate_clock_out [*2] ##1
        !quarter_rate_clock_out)
        else $error("quarter clock shape wrong");
    a_flags_fixed: assert property (core_flags_and_page[4:3] == 2'b11)
        else $error("read-only status flags changed");

    c_branch: cover property (phase == MCS_PH1 && branch);
    c_bus_write: cover property (bus_done && pwrite && bus_file);
    c_store: cover property (core_wr);
    c_clock_out: cover property (quarter_rate_clock_out);
endmodule : mcs_sequencer

// [inc/mcs_map.svh]
`ifndef MCS_MAP_SVH
`define MCS_MAP_SVH

// data file addresses of the core registers
`define MCS_F_INDIRECT 5'h00
`define MCS_F_TIMER 5'h01
`define MCS_F_PCL 5'h02
`define MCS_F_STATUS 5'h03
`define MCS_F_POINTER 5'h04
`define MCS_F_PORT1 5'h05
`define MCS_F_PORT2 5'h06
`define MCS_F_PORT3 5'h07
`define MCS_F_PORT4 5'h08
`define MCS_F_PORT5 5'h09
`define MCS_F_BANKED 5'h10

// number of special registers per variant
`define MCS_SFR_V0 5'd7
`define MCS_SFR_V1 5'd8
`define MCS_SFR_V2 5'd10

// extra register indexes on the bus (byte address = 4 * index)
`define MCS_IDX_FILE_TOP 8'h1f
`define MCS_IDX_CTRL 8'h20
`define MCS_IDX_PIN_DIRECTION_CONTROL 8'h21
`define MCS_IDX_OPTION 8'h22
`define MCS_IDX_STATE 8'h23
`define MCS_CTRL_RC_BIT 0

// reset values
`define MCS_STATUS_RST 8'h18
`define MCS_POINTER_RST 8'h00
`define MCS_PIN_DIRECTION_CONTROL_RST 8'hff
`define MCS_OPTION_RST 6'h3f

// status layout: page bits, read-only flags
`define MCS_PAGE_LO 5
`define MCS_PAGE_HI 6
`define MCS_STATUS_WMASK 8'he7

// read masks for partial ports and pointer bits that read high
`define MCS_PORT1_MASK 8'h0f
`define MCS_PORT5_MASK 8'hf0
`define MCS_POINTER_OR_V0 8'he0
`define MCS_POINTER_OR_V1 8'h80

// instruction word fields
`define MCS_OP_HI 11
`define MCS_OP_LO 9
`define MCS_OP_NOP 3'h0
`define MCS_OP_LIT 3'h1
`define MCS_OP_STORE 3'h2
`define MCS_OP_LOAD 3'h3
`define MCS_OP_JUMP 3'h5

`endif

// [inc/mcs_pkg.sv]
`include "mcs_map.svh"

package mcs_pkg;
    // one-hot quarter phases of an instruction cycle
    typedef enum logic [3:0] {
        MCS_PH1 = 4'b0001,
        MCS_PH2 = 4'b0010,
        MCS_PH3 = 4'b0100,
        MCS_PH4 = 4'b1000
    } mcs_phase_t;

    // instruction classes understood by the execute stage
    typedef enum logic [2:0] {
        MCS_NOP = `MCS_OP_NOP,
        MCS_LIT = `MCS_OP_LIT,
        MCS_STORE = `MCS_OP_STORE,
        MCS_LOAD = `MCS_OP_LOAD,
        MCS_JUMP = `MCS_OP_JUMP
    } mcs_op_t;
endpackage : mcs_pkg

// [verification/mcs_prog_mem.sv]
// program memory beside the core: one registered word per address
module mcs_prog_mem #(
    parameter int PC_W = 11
) (
    input wire logic pclk,
    input wire logic [PC_W-1:0] prog_addr,
    output logic [11:0] prog_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // small test program; unused words load a marker into the work register
    // so that a word fetched by mistake shows up at once
    function automatic logic [11:0] word_at(input logic [PC_W-1:0] a);
        if (a == {PC_W{1'b1}}) begin
            word_at = 12'h000; // no_operation at the reset vector
        end else begin
            case (a[8:0])
                9'h000: word_at = 12'h25a; // load literal 5a
                9'h001: word_at = 12'h40a; // store to file 0ah
                9'h002: word_at = 12'h208; // load literal 08
                9'h003: word_at = 12'h402; // store to pcl: jump to 008h
                9'h008: word_at = 12'h60a; // load file 0ah back
                9'h009: word_at = 12'ha09; // park in a jump loop
                default: word_at = 12'h2ee; // marker literal
            endcase
        end
    endfunction : word_at

    // one cycle of latency, inside the two the core allows
    always @(posedge pclk) begin
        prog_data <= word_at(prog_addr);
    end
endmodule : mcs_prog_mem

// [verification/tb.sv]
module tb
    import mcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int PC_W = 11;
    localparam logic [10:0] EXP_SEQ [10] = '{11'h000, 11'h001, 11'h002,
        11'h003, 11'h004, 11'h008, 11'h009, 11'h00a, 11'h009, 11'h00a};

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [PC_W-1:0] prog_addr;
    logic [11:0] prog_data;
    logic quarter_rate_clock_out;
    logic [7:0] pin_direction_control;
    logic [5:0] timer_prescale_config;
    int err_count = 0;
    int checks_done = 0;
    logic [10:0] last_addr;
    logic [10:0] seq [10];
    int mon_n = 0;
    int gap = 0;
    bit mon_on = 1'b0;

    mcs_sequencer #(.VARIANT(2)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr),
        .prog_data(prog_data),
        .quarter_rate_clock_out(quarter_rate_clock_out),
        .pin_direction_control(pin_direction_control),
        .timer_prescale_config(timer_prescale_config)
    );

    mcs_prog_mem #(.PC_W(PC_W)) i_mem (
        .pclk(pclk), .prog_addr(prog_addr), .prog_data(prog_data)
    );

    // 40 MHz clock
    always #12.5 pclk = ~pclk;

    task results;
        if (err_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : chk

    // one apb transfer; read data is taken at the edge that sees pready,
    // then the task returns on the falling edge so outputs have settled
    task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
        output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {22'h0, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask : apb

    task wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, idx, d, rd, er);
    endtask : wr

    task rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic er;
        apb(1'b0, idx, 32'h0, rd, er);
        chk(rd, exp);
    endtask : rd_chk

    // reset held two cycles; outputs checked while it is held
    task do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        chk({21'h0, prog_addr}, 32'h7ff);
        chk({24'h0, pin_direction_control}, 32'hff);
        chk({26'h0, timer_prescale_config}, 32'h3f);
        chk({31'h0, quarter_rate_clock_out}, 32'h0);
        @(posedge pclk);
        @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    // fetch address trace of the first run, with the spacing of each step
    always @(negedge pclk) begin
        if (mon_on && mon_n < 10) begin
            gap++;
            if (prog_addr !== last_addr) begin
                seq[mon_n] = prog_addr;
                if (mon_n > 0) chk(gap, 32'd4);
                mon_n++;
                gap = 0;
            end
        end
        last_addr = prog_addr;
    end

    task t_pipeline;
        logic [31:0] rd;
        logic er;
        for (int i = 0; i < 200 && mon_n < 10; i++) @(posedge pclk);
        for (int i = 0; i < 10; i++) begin
            chk({21'h0, seq[i]}, {21'h0, EXP_SEQ[i]});
        end
        apb(1'b0, 8'h23, 32'h0, rd, er);
        chk({24'h0, rd[23:16]}, 32'h5a);
        rd_chk(8'h0a, 32'h5a);
        rd_chk(8'h03, 32'h18);
        apb(1'b0, 8'h02, 32'h0, rd, er);
        chk({31'h0, rd === 32'h9 || rd === 32'ha}, 32'h1);
        wr(8'h02, 32'h80);
        apb(1'b0, 8'h23, 32'h0, rd, er);
        chk({31'h0, rd[10:0] == 11'h9 || rd[10:0] == 11'ha}, 32'h1);
    endtask : t_pipeline

    task t_registers;
        logic [31:0] rd;
        logic er;
        wr(8'h04, 32'h0b);
        wr(8'h00, 32'h33);
        rd_chk(8'h0b, 32'h33);
        rd_chk(8'h00, 32'h33);
        wr(8'h04, 32'h10);
        wr(8'h00, 32'h11);
        wr(8'h04, 32'h30);
        wr(8'h00, 32'h22);
        rd_chk(8'h00, 32'h22);
        wr(8'h04, 32'h10);
        rd_chk(8'h00, 32'h11);
        wr(8'h05, 32'hff);
        rd_chk(8'h05, 32'h0f);
        wr(8'h09, 32'hff);
        rd_chk(8'h09, 32'hf0);
        wr(8'h08, 32'ha5);
        rd_chk(8'h08, 32'ha5);
        apb(1'b0, 8'h30, 32'h0, rd, er);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        wr(8'h21, 32'h0f);
        chk({24'h0, pin_direction_control}, 32'h0f);
        wr(8'h22, 32'h15);
        chk({26'h0, timer_prescale_config}, 32'h15);
    endtask : t_registers

    // quarter-rate output: still while the mode is off, then 2 high 2 low
    task t_quarter_clock;
        logic [6:0] pat;
        int n;
        pat = 7'b1100110;
        repeat (8) @(negedge pclk);
        chk({31'h0, quarter_rate_clock_out}, 32'h0);
        wr(8'h20, 32'h1);
        n = 0;
        while (quarter_rate_clock_out !== 1'b0 && n < 20) begin
            @(negedge pclk);
            n++;
        end
        while (quarter_rate_clock_out !== 1'b1 && n < 20) begin
            @(negedge pclk);
            n++;
        end
        for (int i = 6; i >= 0; i--) begin
            chk({31'h0, quarter_rate_clock_out}, {31'h0, pat[i]});
            @(negedge pclk);
        end
    endtask : t_quarter_clock

    // reset in mid-run: the reset vector stands one cycle, then address zero
    task t_mid_reset;
        do_reset();
        repeat (4) @(negedge pclk);
        chk({21'h0, prog_addr}, 32'h7ff);
        repeat (2) @(negedge pclk);
        chk({21'h0, prog_addr}, 32'h000);
    endtask : t_mid_reset

    initial begin
        last_addr = 11'h7ff;
        do_reset();
        mon_on = 1'b1;
        t_pipeline();
        t_registers();
        t_quarter_clock();
        mon_on = 1'b0;
        t_mid_reset();
        results();
    end

    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge pclk);
        err_count++;
        results();
    end
endmodule : tb
